// ===== logic/sarp_top.sv
// alarm thresholds, notch and resonance-mode parameters with an apb slave
//
// Decided for this implementation: register access over APB.
module sarp_top
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// drive state, same clock domain
	input wire sarp_pkg::sarp_ctrl_mode_t i_ctrl_mode,
	input wire logic i_ctrl_tick,
	input wire logic signed [15:0] i_speed_cmd,
	input wire logic signed [15:0] i_speed_meas,
	input wire logic signed [31:0] i_pos_cmd_delta,
	input wire logic signed [31:0] i_pos_fb_delta,
	input wire logic i_alarm_clear,
	input wire logic i_mech_stable,
	input wire logic i_restart,
	// pin from outside, synchronised here
	input wire logic i_deviation_clear_input,
	// outputs
	output logic o_overspeed_alarm,
	output logic o_excessive_deviation_alarm,
	output logic signed [31:0] o_pos_error,
	output logic o_notch_one_enable,
	output logic o_notch_two_enable,
	output logic [15:0] o_notch_one_frequency,
	output logic [15:0] o_notch_one_attenuation,
	output logic [15:0] o_notch_two_frequency,
	output logic [15:0] o_notch_two_attenuation,
	output logic o_notch_adapt,
	output logic o_estimate_start,
	output logic [15:0] o_resonance_sensitivity,
	output logic [11:0] o_feedback_cutoff_hz
);
	import sarp_pkg::*;

	// ************************************************************************
	// parameter storage
	// ************************************************************************
	logic [15:0] overspeed_threshold_r;
	logic [31:0] deviation_threshold_r;
	logic [15:0] notch1_freq_r;
	logic [15:0] notch1_attn_r;
	logic [15:0] notch2_freq_r;
	logic [15:0] notch2_attn_r;
	sarp_res_mode_t res_mode_r;
	logic [15:0] res_sens_r;
	logic [4:0] fb_select_r;
	logic clr_mode_r;
	// saved notch one pair and memorised suppression point
	logic [15:0] saved_freq_r;
	logic [15:0] saved_attn_r;
	logic point_valid_r; // suppression point memorised

	// ************************************************************************
	// apb decode
	// ************************************************************************
	wire [9:0] word_idx = i_paddr[ADDR_MSB:ADDR_LSB];
	wire access = i_psel && i_penable; // zero wait state: pready always high
	wire wr = access && i_pwrite;
	wire hi_half = word_idx[0]; // second word of a parameter
	wire [9:0] base_idx = {word_idx[9:1], 1'b0};
	wire [15:0] wdat = i_pwdata[15:0];
	wire sel_os = base_idx == IDX_OVERSPEED;
	wire sel_dev = base_idx == IDX_DEVIATION;
	wire sel_n1f = base_idx == IDX_NOTCH1_FREQ;
	wire sel_n1a = base_idx == IDX_NOTCH1_ATTN;
	wire sel_n2f = base_idx == IDX_NOTCH2_FREQ;
	wire sel_n2a = base_idx == IDX_NOTCH2_ATTN;
	wire sel_rm = base_idx == IDX_RES_MODE;
	wire sel_rs = base_idx == IDX_RES_SENS;
	wire sel_fb = base_idx == IDX_FB_SELECT;
	wire sel_cm = base_idx == IDX_CLR_MODE;
	wire sel_st = base_idx == IDX_STATUS;
	wire sel_sv = base_idx == IDX_SAVED_NOTCH;
	wire mapped = sel_os | sel_dev | sel_n1f | sel_n1a | sel_n2f | sel_n2a | sel_rm
		| sel_rs | sel_fb | sel_cm | sel_st | sel_sv;
	// 16-bit parameters live in the first word only; second word reads zero
	wire wr16 = wr && !hi_half;
	// deviation threshold: either word is merged with the stored other word and the whole is checked
	wire [31:0] dev_cand = hi_half ? {wdat, deviation_threshold_r[15:0]}
		: {deviation_threshold_r[31:16], wdat};
	// out-of-range values are refused so the stored value stays legal
	wire ok_os = wdat >= MIN_OVERSPEED && wdat <= RST_OVERSPEED;
	wire ok_dev = dev_cand >= MIN_DEVIATION && dev_cand <= MAX_DEVIATION;
	wire ok_nf = wdat == 16'h0000 || (wdat >= MIN_NOTCH_FREQ && wdat <= MAX_NOTCH_FREQ);
	wire ok_na = wdat <= MAX_NOTCH_ATTN;
	wire ok_rm = wdat <= {14'h0000, RES_MODE_MAX};
	wire ok_rs = wdat >= MIN_RES_SENS && wdat <= MAX_RES_SENS;
	wire ok_fb = wdat[15:5] == 11'h000;
	wire ok_cm = wdat[15:1] == 15'h0000;
	// a refused write still completes, but raises pslverr
	wire bad = (sel_os && hi_half == 1'b0 && !ok_os) || (sel_dev && !ok_dev)
		|| (!hi_half && ((sel_n1f || sel_n2f) && !ok_nf || (sel_n1a || sel_n2a) && !ok_na
		|| sel_rm && !ok_rm || sel_rs && !ok_rs || sel_fb && !ok_fb || sel_cm && !ok_cm));
	wire wr_rm = wr16 && sel_rm && ok_rm;
	wire wr_rm_one = wr_rm && wdat[1:0] == RES_ONE_SHOT;

	// ************************************************************************
	// resonance mode controller
	// ************************************************************************
	// one-shot finishes when mechanics settle: memorise, freeze, drop to off
	wire one_shot_done = res_mode_r == RES_ONE_SHOT && i_mech_stable;
	wire cont_stable = res_mode_r == RES_CONTINUOUS && i_mech_stable;
	sarp_res_mode_t res_mode_nxt;
	assign res_mode_nxt = wr_rm ? sarp_res_mode_t'(wdat[1:0])
		: one_shot_done ? RES_OFF : res_mode_r;
	// leaving 1 or 2 for 0 saves notch one settings
	wire to_off = res_mode_r != RES_OFF && res_mode_nxt == RES_OFF;
	// writing 1, or a restart in mode 1 or 2, while unstable starts a fresh estimation
	wire est_nxt = !i_mech_stable && (wr_rm_one
		|| (i_restart && res_mode_r != RES_OFF));

	// ************************************************************************
	// deviation clear input: synchroniser then edge or level
	// ************************************************************************
	logic clr_s1_r;
	logic clr_s2_r;
	logic clr_s3_r;
	wire clr_rise = clr_s2_r && !clr_s3_r;
	wire clr_fire = clr_mode_r ? clr_s2_r : clr_rise;
	wire pos_mode = i_ctrl_mode == CTRL_PULSE_POSITION || i_ctrl_mode == CTRL_REGISTER_POSITION;

	// ************************************************************************
	// error accumulation and comparators
	// ************************************************************************
	wire signed [31:0] pos_err_nxt = o_pos_error + i_pos_cmd_delta - i_pos_fb_delta;
	wire [31:0] pos_err_abs = o_pos_error[31] ? 32'(-o_pos_error) : o_pos_error;
	wire signed [16:0] spd_diff = 17'(i_speed_cmd) - 17'(i_speed_meas);
	wire [16:0] spd_abs = spd_diff[16] ? 17'(-spd_diff) : spd_diff;
	wire os_hit = i_ctrl_mode == CTRL_SPEED
		&& spd_abs > {1'b0, overspeed_threshold_r};
	wire dev_hit = pos_mode && pos_err_abs > deviation_threshold_r;

	// ************************************************************************
	// register writes
	// ************************************************************************
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			overspeed_threshold_r <= RST_OVERSPEED;
			deviation_threshold_r <= RST_DEVIATION;
			notch1_freq_r <= RST_NOTCH_FREQ;
			notch1_attn_r <= RST_NOTCH_ATTN;
			notch2_freq_r <= RST_NOTCH_FREQ;
			notch2_attn_r <= RST_NOTCH_ATTN;
			res_sens_r <= RST_RES_SENS;
			fb_select_r <= RST_FB_SELECT;
			clr_mode_r <= 1'b0;
		end
		else
		begin
			if (wr16 && sel_os && ok_os)
			begin
				overspeed_threshold_r <= wdat;
			end
			if (wr && sel_dev && ok_dev)
			begin
				deviation_threshold_r <= dev_cand;
			end
			// notch one is frozen unless software writes it
			if (wr16 && sel_n1f && ok_nf)
			begin
				notch1_freq_r <= wdat;
			end
			if (wr16 && sel_n1a && ok_na)
			begin
				notch1_attn_r <= wdat;
			end
			if (wr16 && sel_n2f && ok_nf)
			begin
				notch2_freq_r <= wdat;
			end
			if (wr16 && sel_n2a && ok_na)
			begin
				notch2_attn_r <= wdat;
			end
			if (wr16 && sel_rs && ok_rs)
			begin
				res_sens_r <= wdat;
			end
			if (wr16 && sel_fb && ok_fb)
			begin
				fb_select_r <= wdat[4:0];
			end
			if (wr16 && sel_cm && ok_cm)
			begin
				clr_mode_r <= wdat[0];
			end
		end
	end

	// resonance mode, save and estimation pulse
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			res_mode_r <= RES_OFF;
			saved_freq_r <= RST_NOTCH_FREQ;
			saved_attn_r <= RST_NOTCH_ATTN;
			point_valid_r <= 1'b0;
			o_estimate_start <= 1'b0;
		end
		else
		begin
			res_mode_r <= res_mode_nxt;
			o_estimate_start <= est_nxt;
			if (to_off)
			begin
				saved_freq_r <= notch1_freq_r;
				saved_attn_r <= notch1_attn_r;
			end
			// a fresh estimation forgets the old point
			if (est_nxt)
			begin
				point_valid_r <= 1'b0;
			end
			else if (one_shot_done || cont_stable)
			begin
				point_valid_r <= 1'b1;
			end
		end
	end

	// synchroniser, position error and alarms
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			clr_s1_r <= 1'b0;
			clr_s2_r <= 1'b0;
			clr_s3_r <= 1'b0;
			o_pos_error <= 32'sh0000_0000;
			o_overspeed_alarm <= 1'b0;
			o_excessive_deviation_alarm <= 1'b0;
		end
		else
		begin
			clr_s1_r <= i_deviation_clear_input;
			clr_s2_r <= clr_s1_r;
			clr_s3_r <= clr_s2_r;
			// clear wins over accumulation only in position modes
			if (pos_mode && clr_fire)
			begin
				o_pos_error <= 32'sh0000_0000;
			end
			else if (pos_mode && i_ctrl_tick)
			begin
				o_pos_error <= pos_err_nxt;
			end
			// alarms sticky; a new hit wins over the clear
			if (i_ctrl_tick && os_hit)
			begin
				o_overspeed_alarm <= 1'b1;
			end
			else if (i_alarm_clear)
			begin
				o_overspeed_alarm <= 1'b0;
			end
			if (i_ctrl_tick && dev_hit)
			begin
				o_excessive_deviation_alarm <= 1'b1;
			end
			else if (i_alarm_clear)
			begin
				o_excessive_deviation_alarm <= 1'b0;
			end
		end
	end

	// ************************************************************************
	// cutoff table and derived outputs
	// ************************************************************************
	logic [11:0] cutoff;
	always_comb
	begin
		// every 5-bit code is listed, so no default is needed
		unique case (fb_select_r)
			5'h00: cutoff = 12'h9C4; // 2500 Hz
			5'h01: cutoff = 12'h8CA; // 2250 Hz
			5'h02: cutoff = 12'h834; // 2100 Hz
			5'h03: cutoff = 12'h7D0; // 2000 Hz
			5'h04: cutoff = 12'h708; // 1800 Hz
			5'h05: cutoff = 12'h640; // 1600 Hz
			5'h06: cutoff = 12'h5DC; // 1500 Hz
			5'h07: cutoff = 12'h578; // 1400 Hz
			5'h08: cutoff = 12'h514; // 1300 Hz
			5'h09: cutoff = 12'h4B0; // 1200 Hz
			5'h0A: cutoff = 12'h44C; // 1100 Hz
			5'h0B: cutoff = 12'h3E8; // 1000 Hz
			5'h0C: cutoff = 12'h3B6; // 950 Hz
			5'h0D: cutoff = 12'h384; // 900 Hz
			5'h0E: cutoff = 12'h352; // 850 Hz
			5'h0F: cutoff = 12'h320; // 800 Hz
			5'h10: cutoff = 12'h2EE; // 750 Hz
			5'h11: cutoff = 12'h2BC; // 700 Hz
			5'h12: cutoff = 12'h28A; // 650 Hz
			5'h13: cutoff = 12'h258; // 600 Hz
			5'h14: cutoff = 12'h226; // 550 Hz
			5'h15: cutoff = 12'h1F4; // 500 Hz
			5'h16: cutoff = 12'h1C2; // 450 Hz
			5'h17: cutoff = 12'h190; // 400 Hz
			5'h18: cutoff = 12'h15E; // 350 Hz
			5'h19: cutoff = 12'h12C; // 300 Hz
			5'h1A: cutoff = 12'h0FA; // 250 Hz
			5'h1B: cutoff = 12'h0C8; // 200 Hz
			5'h1C: cutoff = 12'h0AF; // 175 Hz
			5'h1D: cutoff = 12'h096; // 150 Hz
			5'h1E: cutoff = 12'h07D; // 125 Hz
			5'h1F: cutoff = 12'h064; // 100 Hz
		endcase
	end
	assign o_feedback_cutoff_hz = cutoff;
	// zero frequency or zero attenuation switches the notch off
	assign o_notch_one_enable = notch1_freq_r != 16'h0000 && notch1_attn_r != 16'h0000;
	assign o_notch_two_enable = notch2_freq_r != 16'h0000 && notch2_attn_r != 16'h0000;
	assign o_notch_one_frequency = notch1_freq_r;
	assign o_notch_one_attenuation = notch1_attn_r;
	assign o_notch_two_frequency = notch2_freq_r;
	assign o_notch_two_attenuation = notch2_attn_r;
	// adapt only while a mode runs; off means frozen
	assign o_notch_adapt = res_mode_r != RES_OFF;
	assign o_resonance_sensitivity = res_sens_r;

	// ************************************************************************
	// read mux
	// ************************************************************************
	wire [15:0] status_word = {11'h000, point_valid_r, o_excessive_deviation_alarm,
		o_overspeed_alarm, res_mode_r};
	wire [15:0] rd_lo = sel_os ? overspeed_threshold_r
		: sel_dev ? deviation_threshold_r[15:0]
		: sel_n1f ? notch1_freq_r
		: sel_n1a ? notch1_attn_r
		: sel_n2f ? notch2_freq_r
		: sel_n2a ? notch2_attn_r
		: sel_rm ? {14'h0000, res_mode_r}
		: sel_rs ? res_sens_r
		: sel_fb ? {11'h000, fb_select_r}
		: sel_cm ? {15'h0000, clr_mode_r}
		: sel_st ? status_word
		: sel_sv ? saved_freq_r : 16'h0000;
	wire [15:0] rd_hi = sel_dev ? deviation_threshold_r[31:16]
		: sel_sv ? saved_attn_r : 16'h0000;
	// the read word is latched in the setup cycle so that the access cycle drives
	// prdata from a flop; a status bit that moves in between shows on the next read
	wire rd_setup = i_psel && !i_penable && !i_pwrite;
	wire [31:0] prdata_nxt = rd_setup ? {16'h0000, hi_half ? rd_hi : rd_lo}
		: 32'h0000_0000;
	logic [31:0] prdata_r;
	// cleared outside a read so that an idle bus sees zero
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			prdata_r <= 32'h0000_0000;
		end
		else
		begin
			prdata_r <= prdata_nxt;
		end
	end
	assign o_prdata = prdata_r;
	assign o_pready = 1'b1;
	assign o_pslverr = access && (!mapped || (i_pwrite && bad));
endmodule : sarp_top

// ===== logic/sarp_pkg.sv
// package of constants and types for the servo alarm and resonance parameter block
// ****************************************************************************
// ****************************************************************************
package sarp_pkg;
	// ************************************************************************
	// register word addresses (byte address is four times the index)
	// ************************************************************************
	localparam logic [9:0] IDX_OVERSPEED = 10'h244;
	localparam logic [9:0] IDX_DEVIATION = 10'h246;
	localparam logic [9:0] IDX_NOTCH1_FREQ = 10'h256;
	localparam logic [9:0] IDX_NOTCH1_ATTN = 10'h258;
	localparam logic [9:0] IDX_NOTCH2_FREQ = 10'h25A;
	localparam logic [9:0] IDX_NOTCH2_ATTN = 10'h25C;
	localparam logic [9:0] IDX_RES_MODE = 10'h25E;
	localparam logic [9:0] IDX_RES_SENS = 10'h260;
	localparam logic [9:0] IDX_FB_SELECT = 10'h262;
	localparam logic [9:0] IDX_CLR_MODE = 10'h264;
	// block's own status and saved-notch words
	localparam logic [9:0] IDX_STATUS = 10'h270;
	localparam logic [9:0] IDX_SAVED_NOTCH = 10'h272;
	localparam int ADDR_LSB = 2;
	localparam int ADDR_MSB = 11;
	// ************************************************************************
	// reset values and legal ranges
	// ************************************************************************
	localparam logic [15:0] RST_OVERSPEED = 16'h1388;
	localparam logic [15:0] MIN_OVERSPEED = 16'h0001;
	localparam logic [31:0] RST_DEVIATION = 32'h003A_9800;
	localparam logic [31:0] MIN_DEVIATION = 32'h0000_0001;
	localparam logic [31:0] MAX_DEVIATION = 32'h07A1_2000;
	localparam logic [15:0] RST_NOTCH_FREQ = 16'h03E8;
	localparam logic [15:0] MIN_NOTCH_FREQ = 16'h0032;
	localparam logic [15:0] MAX_NOTCH_FREQ = 16'h07D0;
	localparam logic [15:0] RST_NOTCH_ATTN = 16'h0000;
	localparam logic [15:0] MAX_NOTCH_ATTN = 16'h0020;
	localparam logic [15:0] RST_RES_SENS = 16'h0064;
	localparam logic [15:0] MIN_RES_SENS = 16'h0001;
	localparam logic [15:0] MAX_RES_SENS = 16'h012C;
	localparam logic [4:0] RST_FB_SELECT = 5'h0B;
	localparam logic [1:0] RES_MODE_MAX = 2'h2;
	localparam logic [3:0] ERR_SLVERR_NONE = 4'h0;
	// ************************************************************************
	// control modes and resonance modes
	// ************************************************************************
	typedef enum logic [1:0] {
		CTRL_PULSE_POSITION,
		CTRL_REGISTER_POSITION,
		CTRL_SPEED,
		CTRL_TORQUE
	} sarp_ctrl_mode_t;
	typedef enum logic [1:0] {
		RES_OFF,
		RES_ONE_SHOT,
		RES_CONTINUOUS
	} sarp_res_mode_t;
endpackage : sarp_pkg

// ===== bench/sarp_monitor.sv
// checker: port-level assertions for the servo alarm and resonance parameter block
module sarp_monitor
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire sarp_pkg::sarp_ctrl_mode_t i_ctrl_mode,
	input wire logic i_ctrl_tick,
	input wire logic i_alarm_clear,
	input wire logic i_restart,
	input wire logic o_overspeed_alarm,
	input wire logic o_excessive_deviation_alarm,
	input wire logic signed [31:0] o_pos_error,
	input wire logic o_notch_one_enable,
	input wire logic [15:0] o_notch_one_frequency,
	input wire logic [15:0] o_notch_one_attenuation,
	input wire logic o_notch_adapt,
	input wire logic o_estimate_start
);
	timeunit 1ns;
	timeprecision 1ns;
	import sarp_pkg::*;
	// ************************************************************************
	// helpers
	// ************************************************************************
	// any write access, and one aimed at the resonance mode word
	wire logic any_wr = i_psel && i_penable && i_pwrite;
	wire logic mode_wr = any_wr && i_paddr[11:2] == IDX_RES_MODE;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	// a clear in a cycle with no control tick cannot meet a fresh hit
	sequence s_quiet_clear;
		i_alarm_clear && !i_ctrl_tick;
	endsequence
	// ************************************************************************
	// assertions
	// ************************************************************************
	a_clear_drops:
		assert property (s_quiet_clear |=> !o_overspeed_alarm && !o_excessive_deviation_alarm)
		else $error("alarm survived a clear");
	a_speed_hold:
		assert property (o_overspeed_alarm && !i_alarm_clear |=> o_overspeed_alarm)
		else $error("overspeed alarm dropped without a clear");
	a_speed_cause:
		assert property ($rose(o_overspeed_alarm) |-> $past(i_ctrl_tick && i_ctrl_mode == CTRL_SPEED))
		else $error("overspeed alarm rose without a speed-mode tick");
	a_dev_cause:
		assert property ($rose(o_excessive_deviation_alarm) |-> $past(i_ctrl_tick && !i_ctrl_mode[1]))
		else $error("deviation alarm rose without a position-mode tick");
	a_notch_gate:
		assert property (o_notch_one_enable == (o_notch_one_frequency != 16'h0 && o_notch_one_attenuation != 16'h0))
		else $error("notch one enable disagrees with its settings");
	a_notch_frozen:
		assert property (!o_notch_adapt && !any_wr |=> $stable(o_notch_one_frequency))
		else $error("notch one moved while frozen");
	a_pos_hold:
		assert property (i_ctrl_mode[1] |=> $stable(o_pos_error))
		else $error("position error moved outside position modes");
	a_estimate_cause:
		assert property (o_estimate_start |-> $past(i_restart || mode_wr))
		else $error("estimation started without restart or mode write");
endmodule : sarp_monitor
bind sarp_top sarp_monitor mon_u (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
	.i_ctrl_mode, .i_ctrl_tick, .i_alarm_clear, .i_restart, .o_overspeed_alarm,
	.o_excessive_deviation_alarm, .o_pos_error, .o_notch_one_enable, .o_notch_one_frequency,
	.o_notch_one_attenuation, .o_notch_adapt, .o_estimate_start);

// ===== bench/sarp_motor_model.sv
// behavioural motor and encoder on the far side of the block
module sarp_motor_model
(
	input wire logic signed [15:0] i_speed_cmd,
	input wire logic signed [15:0] i_slip,
	input wire logic signed [31:0] i_pos_cmd_delta,
	input wire logic signed [31:0] i_lag,
	output logic signed [15:0] o_speed_meas,
	output logic signed [31:0] o_pos_fb_delta
);
	timeunit 1ns;
	timeprecision 1ns;
	// measured speed trails the command by the slip the bench sets
	assign o_speed_meas = i_speed_cmd - i_slip;
	// encoder falls behind the command by a set pulse count each cycle
	assign o_pos_fb_delta = i_pos_cmd_delta - i_lag;
endmodule : sarp_motor_model

// ===== bench/sarp_top_tb.sv
// self-checking testbench for the servo alarm and resonance parameter block
module sarp_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import sarp_pkg::*;
	// ************************************************************************
	// signals
	// ************************************************************************
	logic i_clk = 1'b0, i_rst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
	logic i_ctrl_tick = 1'b0, i_alarm_clear = 1'b0, i_mech_stable = 1'b0, i_restart = 1'b0;
	logic i_deviation_clear_input = 1'b0, o_pready, o_pslverr, o_notch_adapt, o_estimate_start;
	logic o_overspeed_alarm, o_excessive_deviation_alarm, o_notch_one_enable, o_notch_two_enable;
	logic [11:0] i_paddr = 12'h0, o_feedback_cutoff_hz;
	logic [31:0] i_pwdata = 32'h0, o_prdata;
	sarp_ctrl_mode_t i_ctrl_mode = CTRL_SPEED;
	logic signed [15:0] i_speed_cmd = 16'h0, slip = 16'h0, i_speed_meas;
	logic signed [31:0] i_pos_cmd_delta = 32'h0, lag = 32'h0, i_pos_fb_delta, o_pos_error;
	logic [15:0] o_notch_one_frequency, o_notch_one_attenuation, o_notch_two_frequency;
	logic [15:0] o_notch_two_attenuation, o_resonance_sensitivity;
	int error_cnt = 0, num_checks = 0;
	// 25 MHz control clock
	always #20 i_clk = ~i_clk;
	sarp_top dut_u (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
		.o_prdata, .o_pready, .o_pslverr, .i_ctrl_mode, .i_ctrl_tick, .i_speed_cmd, .i_speed_meas,
		.i_pos_cmd_delta, .i_pos_fb_delta, .i_alarm_clear, .i_mech_stable, .i_restart,
		.i_deviation_clear_input, .o_overspeed_alarm, .o_excessive_deviation_alarm, .o_pos_error,
		.o_notch_one_enable, .o_notch_two_enable, .o_notch_one_frequency, .o_notch_one_attenuation,
		.o_notch_two_frequency, .o_notch_two_attenuation, .o_notch_adapt, .o_estimate_start,
		.o_resonance_sensitivity, .o_feedback_cutoff_hz);
	sarp_motor_model motor_u (.i_speed_cmd, .i_slip(slip), .i_pos_cmd_delta, .i_lag(lag),
		.o_speed_meas(i_speed_meas), .o_pos_fb_delta(i_pos_fb_delta));
	// ************************************************************************
	// shared tasks
	// ************************************************************************
	task end_sim;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			error_cnt++;
		end
	endtask : chk
	// one apb transfer: a write judges pslverr, a read judges prdata
	task xf(input logic w, input logic [9:0] idx, input logic [31:0] d, input logic [31:0] exp);
		int n;
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= {idx, 2'h0};
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		@(posedge i_clk);
		// wait is bounded so a stuck slave cannot hang the run
		for (n = 0; n < 16 && o_pready !== 1'b1; n++)
			@(posedge i_clk);
		if (o_pready !== 1'b1)
		begin
			error_cnt++;
			end_sim;
		end
		chk(w ? "pslverr" : "prdata", exp, w ? {31'h0, o_pslverr} : o_prdata);
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask : xf
	// one control tick, then an edge so registered results have landed
	task tick;
		@(posedge i_clk);
		i_ctrl_tick <= 1'b1;
		@(posedge i_clk);
		i_ctrl_tick <= 1'b0;
		@(posedge i_clk);
	endtask : tick
	// ************************************************************************
	// scenarios
	// ************************************************************************
	task t_reset;
		xf(1'b0, IDX_OVERSPEED, 32'h0, 32'h1388);
		xf(1'b0, IDX_DEVIATION, 32'h0, 32'h9800);
		xf(1'b0, IDX_DEVIATION + 10'h1, 32'h0, 32'h3A);
		xf(1'b0, IDX_NOTCH2_FREQ, 32'h0, 32'h3E8);
		xf(1'b0, IDX_FB_SELECT, 32'h0, 32'hB);
		xf(1'b0, IDX_CLR_MODE, 32'h0, 32'h0);
		chk("sensitivity", 32'h64, o_resonance_sensitivity);
		chk("notch_one_freq", 32'h3E8, o_notch_one_frequency);
		chk("cutoff_hz", 32'h3E8, o_feedback_cutoff_hz);
	endtask : t_reset
	task t_ranges;
		xf(1'b1, IDX_OVERSPEED, 32'h1389, 32'h1);
		xf(1'b1, IDX_OVERSPEED + 10'h1, 32'hFFFF, 32'h0);
		xf(1'b0, IDX_OVERSPEED + 10'h1, 32'h0, 32'h0);
		xf(1'b1, IDX_DEVIATION + 10'h1, 32'h7A2, 32'h1);
		xf(1'b1, IDX_RES_SENS, 32'h12D, 32'h1);
		xf(1'b1, IDX_NOTCH1_FREQ, 32'h31, 32'h1);
		xf(1'b1, IDX_NOTCH1_ATTN, 32'h21, 32'h1);
		xf(1'b1, 10'h3FF, 32'h0, 32'h1);
		xf(1'b1, IDX_NOTCH1_ATTN, 32'h20, 32'h0);
		xf(1'b1, IDX_NOTCH2_ATTN, 32'h1, 32'h0);
		@(posedge i_clk);
		chk("notch_enables", 32'h3, {o_notch_one_enable, o_notch_two_enable});
		chk("notch_attn", 32'h0020_0001, {o_notch_one_attenuation, o_notch_two_attenuation});
		chk("notch_two_freq", 32'h3E8, o_notch_two_frequency);
		xf(1'b1, IDX_NOTCH1_FREQ, 32'h0, 32'h0);
		xf(1'b1, IDX_NOTCH2_ATTN, 32'h0, 32'h0);
		@(posedge i_clk);
		chk("notch_enables", 32'h0, {o_notch_one_enable, o_notch_two_enable});
	endtask : t_ranges
	// speed error exactly at the threshold must not trip, one above must
	task t_overspeed;
		i_speed_cmd <= 16'h3E8;
		slip <= 16'h64;
		xf(1'b1, IDX_OVERSPEED, 32'h64, 32'h0);
		tick;
		chk("overspeed", 32'h0, o_overspeed_alarm);
		slip <= 16'h65;
		tick;
		slip <= 16'h0;
		tick;
		chk("overspeed", 32'h1, o_overspeed_alarm);
		i_alarm_clear <= 1'b1;
		@(posedge i_clk);
		i_alarm_clear <= 1'b0;
		@(posedge i_clk);
		chk("overspeed", 32'h0, o_overspeed_alarm);
		// torque mode never compares speed, however large the slip
		i_ctrl_mode <= CTRL_TORQUE;
		slip <= 16'h65;
		tick;
		chk("overspeed", 32'h0, o_overspeed_alarm);
		slip <= 16'h0;
	endtask : t_overspeed
	// error grows by 5 a tick against a threshold of 15, then is cleared
	task t_deviation;
		i_ctrl_mode <= CTRL_PULSE_POSITION;
		i_pos_cmd_delta <= 32'h64;
		lag <= 32'h5;
		xf(1'b1, IDX_DEVIATION + 10'h1, 32'h0, 32'h0);
		xf(1'b1, IDX_DEVIATION, 32'hF, 32'h0);
		repeat (4) tick;
		chk("deviation", 32'h0, o_excessive_deviation_alarm);
		chk("pos_error", 32'h14, o_pos_error);
		tick;
		chk("deviation", 32'h1, o_excessive_deviation_alarm);
		i_deviation_clear_input <= 1'b1;
		repeat (5) @(posedge i_clk);
		chk("pos_error", 32'h0, o_pos_error);
		tick;
		chk("pos_error", 32'h5, o_pos_error);
		// level mode is tried in the other position mode
		i_ctrl_mode <= CTRL_REGISTER_POSITION;
		xf(1'b1, IDX_CLR_MODE, 32'h1, 32'h0);
		tick;
		chk("pos_error", 32'h0, o_pos_error);
		i_deviation_clear_input <= 1'b0;
	endtask : t_deviation
	task t_resonance;
		xf(1'b1, IDX_NOTCH1_FREQ, 32'h7D0, 32'h0);
		xf(1'b1, IDX_RES_MODE, 32'h3, 32'h1);
		xf(1'b1, IDX_RES_MODE, 32'h1, 32'h0);
		@(posedge i_clk);
		chk("estimate", 32'h1, o_estimate_start);
		chk("notch_adapt", 32'h1, o_notch_adapt);
		i_restart <= 1'b1;
		@(posedge i_clk);
		i_restart <= 1'b0;
		@(posedge i_clk);
		chk("estimate", 32'h1, o_estimate_start);
		i_mech_stable <= 1'b1;
		xf(1'b0, IDX_RES_MODE, 32'h0, 32'h0);
		chk("notch_adapt", 32'h0, o_notch_adapt);
		xf(1'b0, IDX_STATUS, 32'h0, 32'h18);
		xf(1'b0, IDX_SAVED_NOTCH, 32'h0, 32'h7D0);
		xf(1'b1, IDX_RES_MODE, 32'h2, 32'h0);
		xf(1'b1, IDX_NOTCH1_ATTN, 32'h8, 32'h0);
		xf(1'b0, IDX_RES_MODE, 32'h0, 32'h2);
		xf(1'b1, IDX_RES_MODE, 32'h0, 32'h0);
		xf(1'b0, IDX_SAVED_NOTCH + 10'h1, 32'h0, 32'h8);
		i_mech_stable <= 1'b0;
	endtask : t_resonance
	task t_cutoff;
		xf(1'b1, IDX_FB_SELECT, 32'h0, 32'h0);
		@(posedge i_clk);
		chk("cutoff_hz", 32'h9C4, o_feedback_cutoff_hz);
		xf(1'b1, IDX_FB_SELECT, 32'h1F, 32'h0);
		@(posedge i_clk);
		chk("cutoff_hz", 32'h64, o_feedback_cutoff_hz);
	endtask : t_cutoff
	// main sequence: reset for six cycles, then each scenario in turn
	initial
	begin
		repeat (6) @(posedge i_clk);
		i_rst_n <= 1'b1;
		t_reset;
		t_ranges;
		t_overspeed;
		t_deviation;
		t_resonance;
		t_cutoff;
		end_sim;
	end
endmodule : sarp_top_tb
